// ### hw/isabi_pkg.sv
package isabi_pkg;
  // cycle kinds offered on the user side of the device end
  typedef enum logic [2:0] {
    ISABI_CYC_NONE,
    ISABI_CYC_CPU_IO,
    ISABI_CYC_CPU_MEM,
    ISABI_CYC_ROM,
    ISABI_CYC_DMA,
    ISABI_CYC_REFRESH,
    ISABI_CYC_MASTER
  } isabi_cyc_t;

  localparam logic [15:0] KBD_DATA_PORT   = 16'h0060;
  localparam logic [15:0] KBD_STATUS_PORT = 16'h0064;
  localparam int          LOW_MEG_LSB     = 20;
  localparam int          LOW_MEG_MSB     = 26;
  // bus command length in mclk cycles (T2 states) without wait or shortening
  localparam int          CMD_TIME_NS     = 400;
  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          CMD_CYCLES      = CMD_TIME_NS / CLK_PERIOD_NS;
  localparam int          ALE_CYCLES      = 1;
  localparam logic        STRAP_LOCAL_RDY = 1'b0;
  localparam logic        KBD_CS_DISABLE  = 1'b1;
endpackage

// ### hw/isabi_if.sv
`timescale 1ns/1ns
`default_nettype none
interface isabi_if;
  // address, strobes: device and far end each have out + enable
  logic [1:0] sa_dev_o;
  logic       sa_dev_oe;
  logic [1:0] sa_far_o;
  logic       sa_far_oe;
  logic [3:0] cmd_dev_o_b;
  logic       cmd_dev_oe;
  logic [3:0] cmd_far_o_b;
  logic       cmd_far_oe;
  logic       sbhe_dev_o_b;
  logic       sbhe_dev_oe;
  logic       sbhe_far_o_b;
  logic       sbhe_far_oe;
  logic       mcs16_dev_o_b;
  logic       mcs16_dev_oe;
  logic       mcs16_far_o_b;
  logic       mcs16_far_oe;
  logic       rfsh_dev_o_b;
  logic       rfsh_dev_oe;
  logic       rfsh_far_o_b;
  logic       rfsh_far_oe;
  logic       ale;
  logic       low_meg_memory_select_b;
  logic       rom_keyboard_select_b;
  logic       iocs16_b;
  logic       iochrdy;
  logic       zero_wait_or_local_ready_pin_b;
  logic       hold;
  logic       hlda;
  // resolved wire levels, pulled up when nobody drives
  logic [1:0] sa;
  logic [3:0] cmd_b;
  logic       sbhe_b, mcs16_b, rfsh_b;
  assign sa      = sa_dev_oe ? sa_dev_o : (sa_far_oe ? sa_far_o : 2'h3);
  assign cmd_b   = cmd_dev_oe ? cmd_dev_o_b
                 : (cmd_far_oe ? cmd_far_o_b : 4'hF);
  assign sbhe_b  = sbhe_dev_oe ? sbhe_dev_o_b
                 : (sbhe_far_oe ? sbhe_far_o_b : 1'b1);
  assign mcs16_b = mcs16_dev_oe ? mcs16_dev_o_b
                 : (mcs16_far_oe ? mcs16_far_o_b : 1'b1);
  assign rfsh_b  = rfsh_dev_oe ? rfsh_dev_o_b
                 : (rfsh_far_oe ? rfsh_far_o_b : 1'b1);

  modport dev (
    output sa_dev_o, sa_dev_oe, cmd_dev_o_b, cmd_dev_oe, sbhe_dev_o_b,
           sbhe_dev_oe, mcs16_dev_o_b, mcs16_dev_oe, rfsh_dev_o_b,
           rfsh_dev_oe, ale, low_meg_memory_select_b,
           rom_keyboard_select_b, hold,
    input  sa, cmd_b, sbhe_b, mcs16_b, rfsh_b, iocs16_b, iochrdy,
           zero_wait_or_local_ready_pin_b, hlda
  );
  modport far (
    output sa_far_o, sa_far_oe, cmd_far_o_b, cmd_far_oe, sbhe_far_o_b,
           sbhe_far_oe, mcs16_far_o_b, mcs16_far_oe, rfsh_far_o_b,
           rfsh_far_oe, iocs16_b, iochrdy,
           zero_wait_or_local_ready_pin_b, hlda,
    input  sa, cmd_b, sbhe_b, mcs16_b, rfsh_b, ale, hold,
           low_meg_memory_select_b, rom_keyboard_select_b
  );
endinterface
`default_nettype wire

// ### hw/isabi_far.sv
`timescale 1ns/1ns
`default_nettype none
// far end: ISA slave responses, ISA master requests and CPU hold grant
module isabi_far (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // link
  isabi_if.far            bus,
  // slave behaviour
  input  wire logic       slv_is16_mem,
  input  wire logic       slv_is16_io,
  input  wire logic       slv_wait,
  input  wire logic       slv_zero_wait,
  input  wire logic       local_rdy,
  input  wire logic       use_local_rdy,
  // master behaviour
  input  wire logic       mst_own,
  input  wire logic [1:0] mst_sa,
  input  wire logic [3:0] mst_cmd_b,
  input  wire logic       mst_sbhe_b,
  input  wire logic       mst_refresh,
  // observed
  output logic            cpu_granted,
  output logic            mcs16_seen_b
);
  logic hold_s1_ff, hold_s2_ff, hlda_ff;
  logic mcs_s1_ff, mcs_s2_ff;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hold_s1_ff <= 1'b0;
      hold_s2_ff <= 1'b0;
    end else begin
      hold_s1_ff <= bus.hold;
      hold_s2_ff <= hold_s1_ff;
    end
  end

  // the cpu grants after seeing hold and releases after hold drops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) hlda_ff <= 1'b0;
    else        hlda_ff <= hold_s2_ff;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mcs_s1_ff <= 1'b1;
      mcs_s2_ff <= 1'b1;
    end else begin
      mcs_s1_ff <= bus.mcs16_b;
      mcs_s2_ff <= mcs_s1_ff;
    end
  end

  assign bus.hlda        = hlda_ff;
  assign cpu_granted     = hlda_ff;
  assign mcs16_seen_b    = mcs_s2_ff;
  // slave side pins; mcs16 is only driven while the far-end master does not own the bus (mst_own low)
  assign bus.mcs16_far_o_b = 1'b0;
  assign bus.mcs16_far_oe  = slv_is16_mem && !mst_own;
  assign bus.iocs16_b      = !slv_is16_io;
  assign bus.iochrdy       = !slv_wait;
  assign bus.zero_wait_or_local_ready_pin_b =
    use_local_rdy ? !local_rdy : !slv_zero_wait;
  // master drives address, strobes and byte-high only once granted
  assign bus.sa_far_o      = mst_sa;
  assign bus.sa_far_oe     = mst_own && hlda_ff;
  assign bus.cmd_far_o_b   = mst_cmd_b;
  assign bus.cmd_far_oe    = mst_own && hlda_ff;
  assign bus.sbhe_far_o_b  = mst_sbhe_b;
  assign bus.sbhe_far_oe   = mst_own && hlda_ff;
  assign bus.rfsh_far_o_b  = 1'b0;
  assign bus.rfsh_far_oe   = mst_refresh;
endmodule
`default_nettype wire

// ### hw/isabi_dev.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - drive SA[1:0] except during master cycles
// - drive command strobes in cpu, dma cycles
// - ALE only while address lines valid
// - byte-high enable marks upper lane transfers
// - low-meg select on refresh or low address
// - drive MCS16 low during master cycles
// - IOCS16 is an input from slaves
// - IOCHRDY low stretches the current cycle
// - strap sampled at reset picks dual pin
// - zero-wait input shortens the isa cycle
// - local ready input drives cpu ready out
// - ROM select first T2 end to last
// - keyboard select on ports 60h and 64h
// - config bit disables keyboard select
// - refresh pin input requests refresh cycle
// - assert HOLD to request cpu bus
// - cpu grants the bus with HLDA
module isabi_dev #(
  parameter int CMD_CYCLES = isabi_pkg::CMD_CYCLES
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  // link
  isabi_if.dev                       bus,
  // strap and configuration
  input  wire logic                  multipurpose_strap_zero,
  input  wire logic                  kbd_select_disable,
  // cycle request from the controller core
  input  wire logic                  req_valid,
  input  wire isabi_pkg::isabi_cyc_t req_kind,
  input  wire logic [26:0]           req_addr,
  input  wire logic                  req_write,
  input  wire logic                  req_hi_byte,
  input  wire logic                  dram_space_select_b,
  output logic                       req_ready,
  // completion and status
  output logic                       done,
  output logic                       cpu_ready_out_b,
  output logic                       local_ready_mode,
  output logic                       refresh_request,
  output logic                       sampled_iocs16_b,
  output logic                       sampled_mcs16_b
);
  typedef enum logic [2:0] {
    ISABI_IDLE, ISABI_HOLD, ISABI_ALE, ISABI_CMD, ISABI_END
  } isabi_state_t;

  isabi_state_t         state_ff, nxt_state;
  isabi_pkg::isabi_cyc_t kind_ff;
  logic [26:0]          addr_ff;
  logic                 write_ff, hi_ff, dram_b_ff;
  logic [7:0]           cnt_ff;
  logic                 strap_ff, rst_seen_ff, done_ff, cpu_ready_out_ff;
  // pin synchronisers: first stage read by second only
  logic [4:0]           pin_s1_ff, pin_s2_ff;
  logic                 hlda_q, rdy_q, zws_q, rfsh_q, iocs_q;
  logic                 mcs_s1_ff, mcs_s2_ff;

  function automatic logic kbd_port(input logic [26:0] a);
    kbd_port = (a[15:0] == isabi_pkg::KBD_DATA_PORT) ||
               (a[15:0] == isabi_pkg::KBD_STATUS_PORT);
  endfunction

  function automatic logic needs_hold(input isabi_pkg::isabi_cyc_t k);
    needs_hold = (k == isabi_pkg::ISABI_CYC_DMA) ||
                 (k == isabi_pkg::ISABI_CYC_REFRESH) ||
                 (k == isabi_pkg::ISABI_CYC_MASTER);
  endfunction

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      // idle pin levels, so no false ready or refresh follows reset
      pin_s1_ff <= 5'h0F;
      pin_s2_ff <= 5'h0F;
      mcs_s1_ff <= 1'b1;
      mcs_s2_ff <= 1'b1;
    end else begin
      pin_s1_ff <= {bus.hlda, bus.iochrdy,
                    bus.zero_wait_or_local_ready_pin_b, bus.rfsh_b,
                    bus.iocs16_b};
      pin_s2_ff <= pin_s1_ff;
      mcs_s1_ff <= bus.mcs16_b;
      mcs_s2_ff <= mcs_s1_ff;
    end
  end
  assign {hlda_q, rdy_q, zws_q, rfsh_q, iocs_q} = pin_s2_ff;

  // strap caught on the first clock after reset release
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_seen_ff <= 1'b0;
      strap_ff    <= 1'b1;
    end else if (!rst_seen_ff) begin
      rst_seen_ff <= 1'b1;
      strap_ff    <= multipurpose_strap_zero;
    end
  end
  assign local_ready_mode = rst_seen_ff &&
                            (strap_ff == isabi_pkg::STRAP_LOCAL_RDY);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ISABI_IDLE: begin
        if (req_valid && req_ready) begin
          if (needs_hold(req_kind)) nxt_state = ISABI_HOLD;
          else nxt_state = ISABI_ALE;
        end
      end
      ISABI_HOLD: begin
        if (hlda_q) begin
          if (kind_ff == isabi_pkg::ISABI_CYC_MASTER) nxt_state = ISABI_CMD;
          else nxt_state = ISABI_ALE;
        end
      end
      ISABI_ALE: nxt_state = ISABI_CMD;
      ISABI_CMD: begin
        // a master ends its own cycle by releasing the strobes
        if (kind_ff == isabi_pkg::ISABI_CYC_MASTER) begin
          if (bus.cmd_b == 4'hF && cnt_ff != 8'h0) nxt_state = ISABI_END;
        end else if (!rdy_q) begin
          nxt_state = ISABI_CMD;
        end else if (!local_ready_mode && !zws_q) begin
          nxt_state = ISABI_END;
        end else if (cnt_ff >= 8'(CMD_CYCLES - 1)) begin
          nxt_state = ISABI_END;
        end
      end
      ISABI_END: nxt_state = ISABI_IDLE;
      default:   nxt_state = ISABI_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) state_ff <= ISABI_IDLE;
    else        state_ff <= nxt_state;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      kind_ff   <= isabi_pkg::ISABI_CYC_NONE;
      addr_ff   <= 27'h0;
      write_ff  <= 1'b0;
      hi_ff     <= 1'b0;
      dram_b_ff <= 1'b1;
    end else if (state_ff == ISABI_IDLE && req_valid && req_ready) begin
      kind_ff   <= req_kind;
      addr_ff   <= req_addr;
      write_ff  <= req_write;
      hi_ff     <= req_hi_byte;
      dram_b_ff <= dram_space_select_b;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)                  cnt_ff <= 8'h0;
    else if (state_ff == ISABI_CMD) cnt_ff <= cnt_ff + 8'h1;
    else                         cnt_ff <= 8'h0;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) done_ff <= 1'b0;
    else        done_ff <= (nxt_state == ISABI_END);
  end

  // local ready mode forwards the vl ready as cpu ready, one cycle after its two-stage synchroniser
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) cpu_ready_out_ff <= 1'b1;
    else        cpu_ready_out_ff <= !(local_ready_mode && !zws_q);
  end

  logic owned, in_cmd, is_master, is_refresh, cmd_io;
  assign is_master  = kind_ff == isabi_pkg::ISABI_CYC_MASTER;
  assign is_refresh = kind_ff == isabi_pkg::ISABI_CYC_REFRESH;
  assign owned      = state_ff != ISABI_IDLE && state_ff != ISABI_HOLD;
  assign in_cmd     = state_ff == ISABI_CMD;
  assign cmd_io     = kind_ff == isabi_pkg::ISABI_CYC_CPU_IO;

  // hold stays up until the transfer has ended
  assign bus.hold   = needs_hold(kind_ff) &&
                      state_ff != ISABI_IDLE;
  // a grant left over from the last transfer must lapse first,
  // else the next hold request would run on a stale grant
  assign req_ready  = state_ff == ISABI_IDLE && rst_seen_ff &&
                      !hlda_q;
  assign done       = done_ff;
  assign cpu_ready_out_b = cpu_ready_out_ff;
  assign refresh_request = !rfsh_q && !bus.rfsh_dev_oe;
  assign sampled_iocs16_b = iocs_q;
  assign sampled_mcs16_b  = mcs_s2_ff;

  assign bus.sa_dev_o   = addr_ff[1:0];
  assign bus.sa_dev_oe  = owned && !is_master;
  assign bus.ale        = state_ff == ISABI_ALE && !is_master;
  assign bus.sbhe_dev_o_b = !hi_ff;
  // released from the hold request on, as the master may drive once granted
  assign bus.sbhe_dev_oe  = !(is_master && state_ff != ISABI_IDLE);
  // strobe order: iord, iowr, memr, memw
  assign bus.cmd_dev_oe  = owned && !is_master && !is_refresh;
  assign bus.cmd_dev_o_b = in_cmd ? (cmd_io ? {write_ff, !write_ff, 2'h3}
                                            : {2'h3, write_ff, !write_ff})
                                  : 4'hF;
  assign bus.mcs16_dev_o_b = 1'b0;
  assign bus.mcs16_dev_oe  = is_master && state_ff != ISABI_IDLE;
  assign bus.rfsh_dev_o_b  = 1'b0;
  assign bus.rfsh_dev_oe   = owned && is_refresh;
  assign bus.low_meg_memory_select_b =
    !((owned && is_refresh) ||
      (addr_ff[isabi_pkg::LOW_MEG_MSB:isabi_pkg::LOW_MEG_LSB] == 7'h0 &&
       !dram_b_ff && owned));
  // rom window opens at the end of the first T2 and runs to the last
  assign bus.rom_keyboard_select_b =
    !((in_cmd && cnt_ff != 8'h0 &&
       kind_ff == isabi_pkg::ISABI_CYC_ROM) ||
      (in_cmd && cmd_io && kbd_port(addr_ff) &&
       kbd_select_disable != isabi_pkg::KBD_CS_DISABLE));
endmodule
`default_nettype wire

// ### tb/isabi_properties.sv
`timescale 1ns/1ns
`default_nettype none
module isabi_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // link signals
  input wire logic sa_dev_oe,
  input wire logic sa_far_oe,
  input wire logic cmd_dev_oe,
  input wire logic cmd_far_oe,
  input wire logic sbhe_dev_oe,
  input wire logic mcs16_dev_oe,
  input wire logic mcs16_dev_o_b,
  input wire logic rfsh_dev_oe,
  input wire logic rfsh_dev_o_b,
  input wire logic ale,
  input wire logic hold,
  input wire logic hlda,
  input wire logic low_meg_memory_select_b,
  input wire logic rom_keyboard_select_b
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_sa_master_in: assert property (sa_far_oe |-> !sa_dev_oe)
    else $error("sa driven by both ends");
  a_cmd_master_in: assert property (cmd_far_oe |-> !cmd_dev_oe)
    else $error("strobes driven by both ends");
  a_ale_addr_valid: assert property (ale |-> sa_dev_oe && sbhe_dev_oe)
    else $error("ale without address");
  a_ale_one_cycle: assert property ($rose(ale) |=> !ale)
    else $error("ale longer than one cycle");
  a_sbhe_dev_owns: assert property (!hold && !$past(hold) |-> sbhe_dev_oe)
    else $error("sbhe released outside arbitration");
  // master may need a cycle before the device sees its own state change
  a_mcs16_master_low: assert property (cmd_far_oe && $past(cmd_far_oe)
    |-> mcs16_dev_oe && !mcs16_dev_o_b)
    else $error("mcs16 not driven low in master cycle");
  a_refresh_low_meg: assert property (rfsh_dev_oe && !rfsh_dev_o_b
    |-> !low_meg_memory_select_b)
    else $error("low meg select missing in refresh");
  a_refresh_granted: assert property (rfsh_dev_oe && !rfsh_dev_o_b
    |-> hold && hlda)
    else $error("refresh without grant");
  a_grant_bounded: assert property ($rose(hold) |-> ##[1:8] hlda)
    else $error("hold not granted");
  a_select_cpu_only: assert property (!rom_keyboard_select_b
    |-> !cmd_far_oe && !hold)
    else $error("select outside cpu cycle");
endmodule
`default_nettype wire

// ### tb/isabi_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module isabi_tb_top;
  localparam int CMD = 4;
  logic                  mclk, rst_b, strap, kdis, req_valid, dram_b;
  isabi_pkg::isabi_cyc_t req_kind;
  logic [26:0]           req_addr;
  logic                  s16, s_wait, s_zw, l_rdy, u_lrdy, m_own, m_rf;
  logic [3:0]            m_cmd;
  logic                  req_ready, done, crdy_b, lrm, rreq;
  int                    n_mismatch, compares;
  int                    n_cmd, n_sel, n_lm, n_rf, n_cr, n_h, n_rr;
  int                    n_far, n_ms, n_sa, n_iord, n_memr;

  isabi_if bus();
  isabi_dev #(.CMD_CYCLES(CMD)) isabi_dev_i (.mclk(mclk), .rst_b(rst_b),
    .bus(bus), .multipurpose_strap_zero(strap), .kbd_select_disable(kdis),
    .req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr),
    .req_write(1'b0), .req_hi_byte(1'b1), .dram_space_select_b(dram_b),
    .req_ready(req_ready), .done(done), .cpu_ready_out_b(crdy_b),
    .local_ready_mode(lrm), .refresh_request(rreq),
    .sampled_iocs16_b(), .sampled_mcs16_b());
  isabi_far isabi_far_i (.mclk(mclk), .rst_b(rst_b), .bus(bus),
    .slv_is16_mem(s16), .slv_is16_io(s16), .slv_wait(s_wait),
    .slv_zero_wait(s_zw), .local_rdy(l_rdy), .use_local_rdy(u_lrdy),
    .mst_own(m_own), .mst_sa(2'h0), .mst_cmd_b(m_cmd), .mst_sbhe_b(1'b1),
    .mst_refresh(m_rf), .cpu_granted(), .mcs16_seen_b());
  isabi_properties isabi_properties_i (.mclk(mclk), .rst_b(rst_b),
    .sa_dev_oe(bus.sa_dev_oe), .sa_far_oe(bus.sa_far_oe),
    .cmd_dev_oe(bus.cmd_dev_oe), .cmd_far_oe(bus.cmd_far_oe),
    .sbhe_dev_oe(bus.sbhe_dev_oe), .mcs16_dev_oe(bus.mcs16_dev_oe),
    .mcs16_dev_o_b(bus.mcs16_dev_o_b), .rfsh_dev_oe(bus.rfsh_dev_oe),
    .rfsh_dev_o_b(bus.rfsh_dev_o_b), .ale(bus.ale), .hold(bus.hold),
    .hlda(bus.hlda), .low_meg_memory_select_b(bus.low_meg_memory_select_b),
    .rom_keyboard_select_b(bus.rom_keyboard_select_b));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset(input logic s);
    strap = s;
    rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
  endtask

  // one transfer, counting what the wire shows until done
  task automatic run(input isabi_pkg::isabi_cyc_t k, input logic [26:0] a);
    int i;
    {n_cmd, n_sel, n_lm, n_rf, n_cr, n_h, n_rr} = '0;
    {n_far, n_ms, n_sa, n_iord, n_memr} = '0;
    i = 0;
    req_kind = k;
    req_addr = a;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && i < 50) begin
      @(negedge mclk);
      i++;
    end
    @(negedge mclk);
    req_valid = 1'b0;
    while (done !== 1'b1 && i < 100) begin
      n_cmd += (bus.cmd_dev_oe === 1'b1 && bus.cmd_b !== 4'hF);
      n_iord += (bus.cmd_b === 4'h7);
      n_memr += (bus.cmd_b === 4'hD);
      n_sel += (bus.rom_keyboard_select_b === 1'b0);
      n_lm += (bus.low_meg_memory_select_b === 1'b0);
      n_rf += (bus.rfsh_dev_oe === 1'b1 && bus.rfsh_b === 1'b0);
      n_cr += (crdy_b === 1'b0);
      n_h += (bus.hold === 1'b1);
      n_rr += (rreq === 1'b1);
      if (bus.cmd_far_oe === 1'b1) begin
        n_far++;
        n_ms += (bus.mcs16_b === 1'b0);
        n_sa += (bus.sa_dev_oe === 1'b1);
        if (n_far > 2) m_cmd = 4'hF;
      end
      // the slave holds its wait only long enough to show a stretch
      if (n_cmd == 6) s_wait = 1'b0;
      @(negedge mclk);
      i++;
    end
    chk("done", 1, (i < 100));
  endtask

  task automatic t_idle;
    chk("hold", 0, bus.hold);
    chk("ale", 0, bus.ale);
    chk("sel", 1, bus.rom_keyboard_select_b);
    chk("lrdy_mode", 1, lrm);
    $display("test idle ended");
  endtask

  task automatic t_kbd;
    logic [15:0] p [4] = '{16'h0060, 16'h0064, 16'h0062, 16'h0060};
    for (int i = 0; i < 4; i++) begin
      kdis = (i == 3);
      run(isabi_pkg::ISABI_CYC_CPU_IO, {11'h000, p[i]});
      chk("kbd_sel", (i < 2), (n_sel != 0));
    end
    kdis = 1'b0;
    chk("cmd_len", CMD, n_cmd);
    chk("iord_len", CMD, n_iord);
    $display("test kbd ended");
  endtask

  task automatic t_rom_lowmeg;
    run(isabi_pkg::ISABI_CYC_ROM, 27'h00F0000);
    chk("rom_sel_len", CMD - 1, n_sel);
    run(isabi_pkg::ISABI_CYC_CPU_MEM, 27'h00F0000);
    chk("low_meg", 1, (n_lm != 0));
    chk("memr_len", CMD, n_memr);
    run(isabi_pkg::ISABI_CYC_CPU_MEM, 27'h0100000);
    chk("low_meg_a20", 0, (n_lm != 0));
    dram_b = 1'b1;
    run(isabi_pkg::ISABI_CYC_CPU_MEM, 27'h0000000);
    chk("low_meg_dram", 0, (n_lm != 0));
    dram_b = 1'b0;
    $display("test rom_lowmeg ended");
  endtask

  task automatic t_ready;
    s_wait = 1'b1;
    run(isabi_pkg::ISABI_CYC_CPU_IO, 27'h0000300);
    chk("stretched", 1, (n_cmd > CMD));
    u_lrdy = 1'b1;
    run(isabi_pkg::ISABI_CYC_CPU_MEM, 27'h0000000);
    chk("cpu_rdy", 1, (n_cr != 0));
    u_lrdy = 1'b0;
    do_reset(1'b1);
    chk("lrdy_mode", 0, lrm);
    s_zw = 1'b1;
    run(isabi_pkg::ISABI_CYC_CPU_IO, 27'h0000300);
    chk("shortened", 1, (n_cmd < CMD));
    s_zw = 1'b0;
    $display("test ready ended");
  endtask

  task automatic t_arb;
    run(isabi_pkg::ISABI_CYC_REFRESH, 27'h0000000);
    chk("hold", 1, (n_h != 0));
    chk("rfsh", 1, (n_rf != 0));
    chk("rfsh_low_meg", 1, (n_lm != 0));
    // let the refresh grant lapse before the master drives on it
    repeat (4) @(negedge mclk);
    m_own = 1'b1;
    m_rf = 1'b1;
    run(isabi_pkg::ISABI_CYC_MASTER, 27'h0000000);
    chk("mcs16_low", 1, (n_ms != 0));
    chk("sa_released", 0, (n_sa != 0));
    chk("rfsh_req", 1, (n_rr != 0));
    m_own = 1'b0;
    m_rf = 1'b0;
    m_cmd = 4'hB;
    repeat (4) @(negedge mclk);
    chk("hold_drop", 0, bus.hold);
    run(isabi_pkg::ISABI_CYC_DMA, 27'h0000400);
    chk("dma_hold", 1, (n_h != 0));
    chk("dma_memr", CMD, n_memr);
    $display("test arb ended");
  endtask

  initial begin
    {rst_b, strap, kdis, req_valid, dram_b, s_wait, s_zw} = '0;
    {l_rdy, u_lrdy, m_own, m_rf} = 4'h8;
    l_rdy = 1'b1;
    s16 = 1'b1;
    m_cmd = 4'hB;
    req_kind = isabi_pkg::ISABI_CYC_NONE;
    req_addr = '0;
    n_mismatch = 0;
    compares = 0;
    do_reset(1'b0);
    t_idle();
    t_kbd();
    t_rom_lowmeg();
    t_arb();
    t_ready();
    report_and_stop();
  end

  initial begin
    #2000000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
